// ### rtl/fbw_pkg.sv
// constants, register map and timing for the flash block write sequencer
// How it works
// - writes go in aligned four-word blocks
// - protected segments refuse self-writes, stay readable
// - serial port ignores write protect, obeys code protect
// - block commit writes four words, erases the 16-word row only for the row's first block
// - go accepted only after 55h then AAh
// - commit only when go hits word 11
// - first three words only load buffer, no halt
// - two setup cycles follow every accepted go
// - halt 2 ms programming, 4 ms with erase
// - write permit clear after power-up
// - no writes while power-up timer runs
// - code protection disables test-mode access
// - read-go and write-go set only, hardware clears
// - unlock port reads all zeros
// - calibration select blocks every flash write
package fbw_pkg;
  localparam logic [7:0] OFF_ADDR_LOW = 8'h00;
  localparam logic [7:0] OFF_ADDR_HIGH = 8'h04;
  localparam logic [7:0] OFF_DATA_LOW = 8'h08;
  localparam logic [7:0] OFF_DATA_HIGH = 8'h0C;
  localparam logic [7:0] OFF_CONTROL = 8'h10;
  localparam logic [7:0] OFF_UNLOCK = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam int CTL_CALIB = 6;
  localparam int CTL_PERMIT = 2;
  localparam int CTL_WR = 1;
  localparam int CTL_RD = 0;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [1:0] LAST_WORD = 2'h3;
  localparam logic [3:0] ERASE_WORD = 4'h3;
  localparam int CLK_KHZ = 125000;
  localparam int SETUP_CYC = 2;
  localparam int HALT_PROG_MS = 2;
  localparam int HALT_ERASE_MS = 4;
  localparam int PWRUP_MS = 72;
  localparam int HALT_PROG_CYC = HALT_PROG_MS * CLK_KHZ;
  localparam int HALT_ERASE_CYC = HALT_ERASE_MS * CLK_KHZ;
  localparam int PWRUP_CYC = PWRUP_MS * CLK_KHZ;
  localparam int CNT_W = 24;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SETUP = 3'h2,
    ST_HALT = 3'h4
  } fbw_state_t;
  // protected region is everything below the limit that wp selects; returns whether a is in it
  function automatic logic fbw_wp_hit(input logic [1:0] wp,
                                      input logic [11:0] a);
    logic [12:0] lim;
    lim = 13'h0000;
    unique case (wp)
      2'h3: lim = 13'h0000;
      2'h2: lim = 13'h0100;
      2'h1: lim = 13'h0800;
      2'h0: lim = 13'h1000;
    endcase
    return {1'b0, a} < lim;
  endfunction
endpackage

// ### rtl/fbw_flash_block_write_sequencer.sv
// flash block write sequencer with AHB-Lite register slave
`timescale 1ns/100ps
module fbw_flash_block_write_sequencer #(
  parameter int unsigned PWRUP_CYC = fbw_pkg::PWRUP_CYC,
  parameter int unsigned HALT_PROG_CYC = fbw_pkg::HALT_PROG_CYC,
  parameter int unsigned HALT_ERASE_CYC = fbw_pkg::HALT_ERASE_CYC
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic [1:0] write_protect_bits_i,
  input wire logic code_protect_i,
  input wire logic ext_serial_prog_i,
  input wire logic test_mode_req_i,
  input wire logic [13:0] fl_rdata_i,
  output logic fl_rd_o,
  output logic [11:0] fl_addr_o,
  output logic fl_calib_sel_o,
  output logic fl_prog_o,
  output logic fl_erase_o,
  output logic [11:0] fl_blk_addr_o,
  output logic [55:0] fl_wdata_o,
  output logic core_halt_o,
  output logic test_mode_en_o
);
  import fbw_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [4:0] sync1;
  logic [4:0] sync2;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1 <= 5'h00;
      sync2 <= 5'h00;
    end else begin
      sync1 <= {test_mode_req_i, ext_serial_prog_i, code_protect_i,
                write_protect_bits_i};
      sync2 <= sync1;
    end
  end
  wire [1:0] wp_s = sync2[1:0];
  wire cp_s = sync2[2];
  wire ext_s = sync2[3];
  wire tmreq_s = sync2[4];

  ////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes zero wait, reads one wait state
  logic ph_wr;
  logic ph_rd;
  logic rd_wait;
  logic [7:0] ph_off;
  wire acc = hsel_i & htrans_i[1] & hready_i;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ph_wr <= 1'b0;
      ph_rd <= 1'b0;
      rd_wait <= 1'b0;
      ph_off <= 8'h00;
    end else begin
      ph_wr <= acc & hwrite_i;
      rd_wait <= ph_rd & ~rd_wait;
      if (acc) begin
        ph_off <= haddr_i[7:0];
        ph_rd <= ~hwrite_i;
      end else if (rd_wait) begin
        ph_rd <= 1'b0;
      end
    end
  end
  assign hreadyout_o = ~(ph_rd & ~rd_wait);
  assign hresp_o = 1'b0;

  wire wr_alo = ph_wr && ph_off == OFF_ADDR_LOW;
  wire wr_ahi = ph_wr && ph_off == OFF_ADDR_HIGH;
  wire wr_dlo = ph_wr && ph_off == OFF_DATA_LOW;
  wire wr_dhi = ph_wr && ph_off == OFF_DATA_HIGH;
  wire wr_ctl = ph_wr && ph_off == OFF_CONTROL;
  wire wr_unl = ph_wr && ph_off == OFF_UNLOCK;

  ////////////////////////////////////////////////////////////////////////
  // registers and sequencer state
  logic [7:0] addr_lo;
  logic [3:0] addr_hi;
  logic [7:0] data_lo;
  logic [5:0] data_hi;
  logic calib_sel;
  logic permit;
  logic wr_bit;
  logic rd_bit;
  logic [1:0] rd_cnt;
  logic [1:0] unl_stage;
  logic refused;
  logic pwrup_done;
  logic [CNT_W-1:0] pwr_cnt;
  logic [CNT_W-1:0] cnt;
  fbw_state_t st;
  logic [13:0] wbuf [4];

  wire [11:0] addr = {addr_hi, addr_lo};
  wire [13:0] data = {data_hi, data_lo};
  wire [1:0] idx = addr_lo[1:0];
  wire busy = st != ST_IDLE;
  wire go_req = wr_ctl & hwdata_i[CTL_WR];
  wire go_ok = go_req && unl_stage == 2'h2 && permit && !busy;
  wire rd_req = wr_ctl & hwdata_i[CTL_RD] & ~rd_bit & ~busy;
  // serial port path skips write protect but not code protect
  wire prot_blk = ext_s ? cp_s : fbw_wp_hit(wp_s, addr);
  wire blocked = calib_sel | ~pwrup_done | prot_blk;
  wire setup_end = st == ST_SETUP && cnt == CNT_W'(SETUP_CYC - 1);
  wire commit = setup_end && !blocked && idx == LAST_WORD;
  wire do_erase = addr_lo[3:0] == ERASE_WORD;

  logic [55:0] next_words;
  always_comb begin
    next_words = 56'h0;
    for (int i = 0; i < 4; i++) begin
      next_words[i*14 +: 14] = (idx == 2'(i)) ? data : wbuf[i];
    end
  end

  // unlock pair must be the two bus writes right before the go
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      unl_stage <= 2'h0;
    end else if (ph_wr) begin
      if (wr_unl && hwdata_i[7:0] == UNLOCK_KEY1) begin
        unl_stage <= 2'h1;
      end else if (wr_unl && hwdata_i[7:0] == UNLOCK_KEY2 &&
                   unl_stage == 2'h1) begin
        unl_stage <= 2'h2;
      end else begin
        unl_stage <= 2'h0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwr_cnt <= '0;
      pwrup_done <= 1'b0;
    end else if (!pwrup_done) begin
      pwr_cnt <= pwr_cnt + 1'b1;
      pwrup_done <= pwr_cnt == CNT_W'(PWRUP_CYC - 1);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      addr_lo <= 8'h00;
      addr_hi <= 4'h0;
      calib_sel <= 1'b0;
      permit <= 1'b0;
    end else begin
      if (wr_alo) addr_lo <= hwdata_i[7:0];
      if (wr_ahi) addr_hi <= hwdata_i[3:0];
      if (wr_ctl) begin
        calib_sel <= hwdata_i[CTL_CALIB];
        permit <= hwdata_i[CTL_PERMIT];
      end
    end
  end

  // read: flash sampled on the third cycle after the go
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      data_lo <= 8'h00;
      data_hi <= 6'h00;
      rd_bit <= 1'b0;
      rd_cnt <= 2'h0;
      fl_rd_o <= 1'b0;
    end else begin
      fl_rd_o <= rd_cnt == 2'h1;
      if (rd_req) begin
        rd_bit <= 1'b1;
        rd_cnt <= 2'h1;
      end else if (rd_cnt == 2'h3) begin
        rd_bit <= 1'b0;
        rd_cnt <= 2'h0;
        {data_hi, data_lo} <= fl_rdata_i;
      end else if (rd_cnt != 2'h0) begin
        rd_cnt <= rd_cnt + 2'h1;
      end
      if (rd_cnt != 2'h3) begin
        if (wr_dlo) data_lo <= hwdata_i[7:0];
        if (wr_dhi) data_hi <= hwdata_i[5:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st <= ST_IDLE;
      cnt <= '0;
      wr_bit <= 1'b0;
      refused <= 1'b0;
      fl_prog_o <= 1'b0;
      fl_erase_o <= 1'b0;
      fl_blk_addr_o <= 12'h000;
      fl_wdata_o <= 56'h0;
      for (int i = 0; i < 4; i++) wbuf[i] <= 14'h0000;
    end else begin
      fl_prog_o <= commit;
      fl_erase_o <= commit & do_erase;
      unique case (st)
        ST_IDLE: begin
          if (go_ok) begin
            wr_bit <= 1'b1;
            refused <= 1'b0;
            cnt <= '0;
            st <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          cnt <= cnt + 1'b1;
          if (setup_end) begin
            if (blocked) begin
              refused <= 1'b1;
              wr_bit <= 1'b0;
              st <= ST_IDLE;
            end else if (commit) begin
              wbuf[idx] <= data;
              fl_wdata_o <= next_words;
              fl_blk_addr_o <= {addr[11:2], 2'h0};
              cnt <= do_erase ? CNT_W'(HALT_ERASE_CYC - 1)
                              : CNT_W'(HALT_PROG_CYC - 1);
              st <= ST_HALT;
            end else begin
              wbuf[idx] <= data;
              wr_bit <= 1'b0;
              st <= ST_IDLE;
            end
          end
        end
        ST_HALT: begin
          cnt <= cnt - 1'b1;
          if (cnt == '0) begin
            wr_bit <= 1'b0;
            st <= ST_IDLE;
          end
        end
      endcase
    end
  end

  assign core_halt_o = st == ST_HALT;
  assign fl_addr_o = addr;
  assign fl_calib_sel_o = calib_sel;
  assign test_mode_en_o = tmreq_s & ~cp_s;

  ////////////////////////////////////////////////////////////////////////
  // read mux; unlock port has no storage
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    unique case (ph_off)
      OFF_ADDR_LOW: rd_mux = {24'h0, addr_lo};
      OFF_ADDR_HIGH: rd_mux = {28'h0, addr_hi};
      OFF_DATA_LOW: rd_mux = {24'h0, data_lo};
      OFF_DATA_HIGH: rd_mux = {26'h0, data_hi};
      OFF_CONTROL: rd_mux = {25'h0, calib_sel, 3'h0, permit, wr_bit, rd_bit};
      OFF_STATUS: rd_mux = {29'h0, refused, pwrup_done, busy};
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) hrdata_o <= 32'h0;
    else if (ph_rd && !rd_wait) hrdata_o <= rd_mux;
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  a_go_unlocked: assert property ($rose(st == ST_SETUP) |->
    $past(unl_stage) == 2'h2 && $past(permit))
    else $error("go accepted without unlock or permit");
  a_setup_two: assert property ($rose(st == ST_SETUP) |->
    (st == ST_SETUP) [*2] ##1 st != ST_SETUP)
    else $error("setup not two cycles");
  a_commit_last: assert property (fl_prog_o |->
    fl_blk_addr_o[1:0] == 2'h0 && $past(idx) == LAST_WORD)
    else $error("commit off last word");
  a_erase_row: assert property (fl_erase_o |->
    fl_prog_o && $past(addr_lo[3:0]) == ERASE_WORD)
    else $error("bad row erase");
  a_halt_cause: assert property ($rose(core_halt_o) |-> fl_prog_o)
    else $error("halt without commit");
  a_buffer_nohalt: assert property (setup_end && idx != LAST_WORD
    |=> st == ST_IDLE && !wr_bit && !core_halt_o)
    else $error("buffer load halted core");
  a_blocked_write: assert property (fl_prog_o |->
    !$past(blocked))
    else $error("blocked write reached flash");
  a_wr_hw_clear: assert property ($fell(wr_bit) |->
    $past(st) != ST_IDLE)
    else $error("write go cleared while idle");
  a_unlock_zero: assert property (rd_wait && ph_off == OFF_UNLOCK |->
    hrdata_o == 32'h0)
    else $error("unlock port read nonzero");
  a_test_locked: assert property (cp_s |-> !test_mode_en_o)
    else $error("test mode under code protect");
endmodule // fbw_flash_block_write_sequencer

// ### sim/fbw_flash_model.sv
// flash array model behind the sequencer
`timescale 1ns/100ps
module fbw_flash_model (
  input wire logic clk_i,
  input wire logic fl_rd_i,
  input wire logic [11:0] fl_addr_i,
  input wire logic fl_prog_i,
  input wire logic fl_erase_i,
  input wire logic [11:0] fl_blk_addr_i,
  input wire logic [55:0] fl_wdata_i,
  output logic [13:0] fl_rdata_o
);
  logic [13:0] mem [4096];
  initial begin
    foreach (mem[k]) mem[k] = 14'h3FFF;
    fl_rdata_o = 14'h0000;
  end
  // read data valid one cycle only, churns otherwise
  always @(posedge clk_i) begin
    fl_rdata_o <= fl_rd_i ? mem[fl_addr_i] : ~fl_rdata_o;
    if (fl_prog_i && fl_erase_i) begin
      for (int k = 0; k < 16; k++) begin
        mem[{fl_blk_addr_i[11:4], k[3:0]}] = 14'h3FFF;
      end
    end
    if (fl_prog_i) begin
      for (int k = 0; k < 4; k++) begin
        mem[{fl_blk_addr_i[11:2], k[1:0]}] =
          fl_wdata_i[k*14 +: 14];
      end
    end
  end
endmodule // fbw_flash_model

// ### sim/tb_top.sv
// self-checking bench for the flash block write sequencer
`timescale 1ns/100ps
module tb_top;
  import fbw_pkg::*;
  // short waits keep the run small
  localparam int PW = 60;
  localparam int HP = 8;
  localparam int HE = 12;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [1:0] wp = 2'h3;
  logic cp = 1'b0;
  logic ext = 1'b0;
  logic tmr = 1'b0;
  logic [31:0] hrdata;
  logic hrdy, hresp, fl_rd, calib, prog, erase, halt, tme;
  logic [13:0] fl_rdata;
  logic [11:0] fl_addr, blk;
  logic [55:0] wdata;
  logic [13:0] emem [4096];
  logic [13:0] ebuf [4];
  int miscompares = 0;
  int checked = 0;
  int prog_n = 0;
  int erase_n = 0;
  int halt_n = 0;
  integer seed = 32'h0DD4;
  fbw_flash_block_write_sequencer #(.PWRUP_CYC(PW), .HALT_PROG_CYC(HP),
    .HALT_ERASE_CYC(HE)) i_fbw_flash_block_write_sequencer (
    .clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(hsel), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata),
    .hreadyout_o(hrdy), .hresp_o(hresp), .write_protect_bits_i(wp),
    .code_protect_i(cp), .ext_serial_prog_i(ext), .test_mode_req_i(tmr),
    .fl_rdata_i(fl_rdata), .fl_rd_o(fl_rd), .fl_addr_o(fl_addr),
    .fl_calib_sel_o(calib), .fl_prog_o(prog), .fl_erase_o(erase),
    .fl_blk_addr_o(blk), .fl_wdata_o(wdata), .core_halt_o(halt),
    .test_mode_en_o(tme));
  fbw_flash_model i_fbw_flash_model (.clk_i(clk_i), .fl_rd_i(fl_rd),
    .fl_addr_i(fl_addr), .fl_prog_i(prog), .fl_erase_i(erase),
    .fl_blk_addr_i(blk), .fl_wdata_i(wdata), .fl_rdata_o(fl_rdata));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    prog_n <= prog_n + int'(prog);
    erase_n <= erase_n + int'(erase);
    halt_n <= halt_n + int'(halt);
  end
  task automatic end_of_test();
    $display("checks %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hrdy !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask
  task automatic word(input logic [11:0] a, input logic [13:0] d,
                      input logic [7:0] k2, input logic pm, input logic cal);
    logic [31:0] c;
    logic [31:0] s;
    c = {25'h0, cal, 3'h0, pm, 2'h0};
    wr(OFF_CONTROL, c);
    wr(OFF_ADDR_LOW, {24'h0, a[7:0]});
    wr(OFF_ADDR_HIGH, {28'h0, a[11:8]});
    wr(OFF_DATA_LOW, {24'h0, d[7:0]});
    wr(OFF_DATA_HIGH, {26'h0, d[13:8]});
    wr(OFF_UNLOCK, 32'h55);
    wr(OFF_UNLOCK, {24'h0, k2});
    wr(OFF_CONTROL, c | 32'h2);
    do bus(1'b0, OFF_STATUS, 32'h0, s); while (s[0] !== 1'b0);
  endtask
  task automatic rb(input logic [11:0] a);
    logic [31:0] l, h;
    wr(OFF_ADDR_LOW, {24'h0, a[7:0]});
    wr(OFF_ADDR_HIGH, {28'h0, a[11:8]});
    wr(OFF_CONTROL, 32'h1);
    repeat (4) @(posedge clk_i);
    bus(1'b0, OFF_DATA_LOW, 32'h0, l);
    bus(1'b0, OFF_DATA_HIGH, 32'h0, h);
    chk(l, {24'h0, emem[a][7:0]});
    chk(h, {26'h0, emem[a][13:8]});
  endtask
  function automatic logic ok_f(input logic [11:0] a, input logic cal);
    logic [12:0] lim;
    lim = wp == 2'h3 ? 13'h0000 : wp == 2'h2 ? 13'h0100 :
          wp == 2'h1 ? 13'h0800 : 13'h1000;
    return !cal && (ext ? !cp : {1'b0, a} >= lim);
  endfunction
  task automatic put(input logic [11:0] a, input logic [13:0] d,
                     input logic cal);
    int p, e, h;
    logic ok, last;
    ok = ok_f(a, cal);
    last = ok && a[1:0] == LAST_WORD;
    p = prog_n;
    e = erase_n;
    h = halt_n;
    word(a, d, 8'hAA, 1'b1, cal);
    rc(OFF_STATUS, {29'h0, ~ok, 2'h2});
    rc(OFF_CONTROL, {25'h0, cal, 6'h4});
    chk({31'h0, calib}, {31'h0, cal});
    chk(32'(prog_n - p), {31'h0, last});
    chk(32'(erase_n - e), {31'h0, last && a[3:2] == 2'h0});
    chk(32'(halt_n - h), !last ? 0 : a[3:2] == 2'h0 ? HE : HP);
    if (ok) ebuf[a[1:0]] = d;
    if (last && a[3:2] == 2'h0) begin
      for (int k = 0; k < 16; k++) emem[{a[11:4], k[3:0]}] = 14'h3FFF;
    end
    if (last) begin
      for (int k = 0; k < 4; k++) emem[{a[11:2], k[1:0]}] = ebuf[k];
    end
  endtask
  initial begin
    #300000;
    miscompares++;
    $display("ERROR %0t: timeout", $time);
    end_of_test();
  end
  initial begin
    logic [31:0] s;
    logic [11:0] base, a;
    logic [13:0] d;
    foreach (emem[k]) emem[k] = 14'h3FFF;
    foreach (ebuf[k]) ebuf[k] = 14'h0;
    repeat (5) @(posedge clk_i);
    rstn_i <= 1'b1;
    rc(OFF_CONTROL, 32'h0);
    rc(OFF_STATUS, 32'h0);
    word(12'h003, 14'h0123, 8'hAA, 1'b1, 1'b0);
    rc(OFF_STATUS, 32'h4);
    do bus(1'b0, OFF_STATUS, 32'h0, s); while (s[1] !== 1'b1);
    word(12'h003, 14'h0123, 8'hAA, 1'b0, 1'b0);
    rc(OFF_STATUS, 32'h6);
    word(12'h003, 14'h0123, 8'h55, 1'b1, 1'b0);
    rc(OFF_STATUS, 32'h6);
    chk(32'(prog_n), 32'h0);
    rc(OFF_UNLOCK, 32'h0);
    wr(8'h1C, 32'hFFFFFFFF);
    rc(8'h1C, 32'h0);
    // every protect code, serial port and code protect mix
    for (int i = 0; i < 16; i++) begin
      wp <= i[1:0];
      ext <= i[2];
      cp <= i[3];
      tmr <= 1'($random(seed));
      base = 12'($random(seed));
      if (i[0]) base[3:2] = 2'h0;
      repeat (4) @(posedge clk_i);
      chk({31'h0, tme}, {31'h0, tmr & ~cp});
      for (int j = 0; j < 4; j++) begin
        a = {base[11:2], j[1:0]};
        d = 14'($random(seed));
        if (j == 1) begin
          rb(a);
          d = emem[a];
        end
        put(a, d, i == 6);
      end
      for (int j = 0; j < 4; j++) rb({base[11:2], j[1:0]});
    end
    // reset in mid-run must drop the write permit again
    wr(OFF_CONTROL, 32'h4);
    rc(OFF_CONTROL, 32'h4);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    rc(OFF_CONTROL, 32'h0);
    rc(OFF_STATUS, 32'h0);
    end_of_test();
  end
endmodule // tb_top
